// ==== shared/sbit_pkg.sv ====
// constants and types shared by the break and idle transmit path
package sbit_pkg;

    // clock and line rate
    localparam int CLK_HZ         = 25_000_000;
    localparam int BAUD_HZ        = 19200;
    localparam int BIT_CYCLES     = CLK_HZ / BAUD_HZ;
    localparam int BAUD_CNT_W     = 16;

    // frame lengths in bit times, chosen by the word-length select, and the mark length after a break
    localparam logic [3:0] FRAME_BITS_SHORT = 4'hA;
    localparam logic [3:0] FRAME_BITS_LONG  = 4'hB;
    localparam logic [3:0] MARK_BITS        = 4'h1;

    // data path
    localparam int DATA_W         = 9;
    localparam int FIFO_DEPTH     = 16;
    localparam int SHIFT_W        = 11;

    // reset values and line levels
    localparam logic LINE_MARK         = 1'b1;
    localparam logic LINE_SPACE        = 1'b0;
    localparam logic TX_ON_RESET       = 1'b1;
    localparam logic BREAK_BIT_RESET   = 1'b0;

    // transmitter states
    typedef enum logic [4:0] {
        SBIT_READY = 5'h01,
        SBIT_IDLE  = 5'h02,
        SBIT_BREAK = 5'h04,
        SBIT_MARK  = 5'h08,
        SBIT_DATA  = 5'h10
    } sbit_state_t;

endpackage

// ==== logic/sbit_fifo.sv ====
// parameterised word FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sbit_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clock_i,
    input  wire logic             resetn_i,
    // filling side
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    // draining side
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;
    logic             full;
    logic             empty;

    assign full        = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty       = (wr_ptr == rd_ptr);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign push        = in_valid_i && !full;
    assign pop         = out_ready_i && !empty;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + {{AW{1'b0}}, 1'b1} : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + {{AW{1'b0}}, 1'b1} : rd_ptr;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // storage has no reset; reads are guarded by empty
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

endmodule

// ==== logic/sbit_tx.sv ====
// asynchronous serial transmitter with break and idle generation
//
// Operation
// - one set-clear of break bit sends one break
// - break lasts ten bit times, short words
// - break lasts eleven bit times, long words
// - break bit held: breaks follow back to back
// - enable cleared then set sends idle frame
// - pending idle goes before pending break
`timescale 1ns/1ps
module sbit_tx #(
    parameter int BIT_CYCLES = sbit_pkg::BIT_CYCLES,
    parameter int DATA_W     = sbit_pkg::DATA_W,
    parameter int FIFO_DEPTH = sbit_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic              clock_i,
    input  wire logic              resetn_i,
    // control from software
    input  wire logic              send_break_bit_i,
    input  wire logic              tx_on_i,
    input  wire logic              word_len_i,
    // data stream
    input  wire logic [DATA_W-1:0] data_i,
    input  wire logic              data_valid_i,
    output logic                   data_ready_o,
    // serial line and status
    output logic                   tx_o,
    output logic                   busy_o
);
    localparam int CW = sbit_pkg::BAUD_CNT_W;
    localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);

    sbit_pkg::sbit_state_t state;
    sbit_pkg::sbit_state_t next_state;
    logic [CW-1:0]                  baud_cnt;
    logic [CW-1:0]                  next_baud_cnt;
    logic [3:0]                     bits_left;
    logic [3:0]                     next_bits_left;
    logic [sbit_pkg::SHIFT_W-1:0]   shift;
    logic [sbit_pkg::SHIFT_W-1:0]   next_shift;
    logic                           frame_long;
    logic                           next_frame_long;
    logic                           pend_break;
    logic                           next_pend_break;
    logic                           pend_idle;
    logic                           next_pend_idle;
    logic                           brk_q;
    logic                           ton_q;
    logic                           line;
    logic                           next_line;
    logic [DATA_W-1:0]              fifo_data;
    logic                           fifo_valid;
    logic                           fifo_pop;
    logic                           bit_end;
    logic                           brk_rise;
    logic                           ton_rise;
    logic                           want_break;
    logic                           idle_req;
    logic                           start_idle;
    logic                           start_break;
    logic                           start_data;

    function automatic logic [3:0] frame_bits(input logic long_word);
        frame_bits = long_word ? sbit_pkg::FRAME_BITS_LONG : sbit_pkg::FRAME_BITS_SHORT;
    endfunction

    sbit_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .resetn_i    (resetn_i),
        .in_data_i   (data_i),
        .in_valid_i  (data_valid_i),
        .in_ready_o  (data_ready_o),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    assign bit_end    = (baud_cnt == BIT_LAST);
    assign brk_rise   = send_break_bit_i && !brk_q;
    assign ton_rise   = tx_on_i && !ton_q;
    assign want_break = pend_break || send_break_bit_i;
    // an enable edge is an idle request in its own cycle; nothing may start ahead of it
    assign idle_req   = pend_idle || ton_rise;
    assign start_idle  = (state == sbit_pkg::SBIT_READY) && tx_on_i && idle_req;
    assign start_break = (state == sbit_pkg::SBIT_READY) && tx_on_i && !idle_req
                         && want_break;
    assign start_data  = (state == sbit_pkg::SBIT_READY) && tx_on_i && !idle_req
                         && !want_break && fifo_valid;
    assign fifo_pop    = start_data;
    assign tx_o        = line;
    assign busy_o      = (state != sbit_pkg::SBIT_READY);

    always_comb begin
        next_state      = state;
        next_baud_cnt   = bit_end ? '0 : baud_cnt + CW'(1);
        next_bits_left  = bits_left;
        next_shift      = shift;
        next_frame_long = frame_long;
        // a request seen now is consumed only by the frame it starts
        next_pend_break = (pend_break || brk_rise) && !start_break;
        next_pend_idle  = idle_req && !start_idle;
        unique case (state)
            sbit_pkg::SBIT_READY: begin
                next_baud_cnt   = '0;
                next_frame_long = word_len_i;
                next_bits_left  = frame_bits(word_len_i) - 4'h1;
                if (start_idle) begin
                    next_state = sbit_pkg::SBIT_IDLE;
                end else if (start_break) begin
                    next_state = sbit_pkg::SBIT_BREAK;
                end else if (start_data) begin
                    next_state = sbit_pkg::SBIT_DATA;
                    next_shift = word_len_i
                        ? {1'b1, fifo_data[8:0], 1'b0}
                        : {2'b11, fifo_data[7:0], 1'b0};
                end
            end
            sbit_pkg::SBIT_IDLE, sbit_pkg::SBIT_DATA: begin
                if (bit_end) begin
                    next_shift = {1'b1, shift[sbit_pkg::SHIFT_W-1:1]};
                    if (bits_left == 4'h0) begin
                        next_state = sbit_pkg::SBIT_READY;
                    end else begin
                        next_bits_left = bits_left - 4'h1;
                    end
                end
            end
            sbit_pkg::SBIT_BREAK: begin
                if (bit_end) begin
                    if (bits_left == 4'h0) begin
                        next_state     = sbit_pkg::SBIT_MARK;
                        next_bits_left = sbit_pkg::MARK_BITS - 4'h1;
                    end else begin
                        next_bits_left = bits_left - 4'h1;
                    end
                end
            end
            sbit_pkg::SBIT_MARK: begin
                if (bit_end) begin
                    next_state = sbit_pkg::SBIT_READY;
                end
            end
            default: begin
                next_state = sbit_pkg::SBIT_READY;
            end
        endcase
        unique case (next_state)
            sbit_pkg::SBIT_BREAK: next_line = sbit_pkg::LINE_SPACE;
            sbit_pkg::SBIT_DATA:  next_line = next_shift[0];
            default:              next_line = sbit_pkg::LINE_MARK;
        endcase
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state      <= sbit_pkg::SBIT_READY;
            baud_cnt   <= '0;
            bits_left  <= 4'h0;
            shift      <= '1;
            frame_long <= 1'b0;
            pend_break <= 1'b0;
            pend_idle  <= 1'b0;
            brk_q      <= sbit_pkg::BREAK_BIT_RESET;
            ton_q      <= sbit_pkg::TX_ON_RESET;
            line       <= sbit_pkg::LINE_MARK;
        end else begin
            state      <= next_state;
            baud_cnt   <= next_baud_cnt;
            bits_left  <= next_bits_left;
            shift      <= next_shift;
            frame_long <= next_frame_long;
            pend_break <= next_pend_break;
            pend_idle  <= next_pend_idle;
            brk_q      <= send_break_bit_i;
            ton_q      <= tx_on_i;
            line       <= next_line;
        end
    end

    // helper: cycles the line has spent low in the current break
    logic [CW-1:0] low_run;
    logic [CW-1:0] next_low_run;

    always_comb begin
        next_low_run = (state == sbit_pkg::SBIT_BREAK) ? low_run + CW'(1) : '0;
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_run <= '0;
        end else begin
            low_run <= next_low_run;
        end
    end

    localparam logic [CW-1:0] BRK_SHORT_CYC = CW'(BIT_CYCLES * 10);
    localparam logic [CW-1:0] BRK_LONG_CYC  = CW'(BIT_CYCLES * 11);

    property p_break_short;
        @(posedge clock_i) disable iff (!resetn_i)
        (state == sbit_pkg::SBIT_BREAK) && (next_state == sbit_pkg::SBIT_MARK) && !frame_long
        |-> (low_run == BRK_SHORT_CYC - CW'(1));
    endproperty
    a_break_short: assert property (p_break_short) else $error("short break length wrong");

    property p_break_long;
        @(posedge clock_i) disable iff (!resetn_i)
        (state == sbit_pkg::SBIT_BREAK) && (next_state == sbit_pkg::SBIT_MARK) && frame_long
        |-> (low_run == BRK_LONG_CYC - CW'(1));
    endproperty
    a_break_long: assert property (p_break_long) else $error("long break length wrong");

    property p_break_low;
        @(posedge clock_i) disable iff (!resetn_i)
        (state == sbit_pkg::SBIT_BREAK) |-> (tx_o == 1'b0);
    endproperty
    a_break_low: assert property (p_break_low) else $error("line high during break");

    property p_mark_after;
        @(posedge clock_i) disable iff (!resetn_i)
        $fell(state == sbit_pkg::SBIT_BREAK) |-> (tx_o == 1'b1) [*2];
    endproperty
    a_mark_after: assert property (p_mark_after) else $error("no mark after break");

    property p_one_break;
        @(posedge clock_i) disable iff (!resetn_i)
        $rose(send_break_bit_i) && (state == sbit_pkg::SBIT_DATA)
        |=> pend_break;
    endproperty
    a_one_break: assert property (p_one_break) else $error("break request lost");

    property p_held_break;
        @(posedge clock_i) disable iff (!resetn_i)
        (state == sbit_pkg::SBIT_READY) && $past(state == sbit_pkg::SBIT_MARK)
        && tx_on_i && send_break_bit_i && !pend_idle |=> (state == sbit_pkg::SBIT_BREAK);
    endproperty
    a_held_break: assert property (p_held_break) else $error("held break not repeated");

    property p_idle_req;
        @(posedge clock_i) disable iff (!resetn_i)
        $rose(tx_on_i) && (state == sbit_pkg::SBIT_READY)
        |=> (state == sbit_pkg::SBIT_IDLE) ##1 (tx_o == 1'b1);
    endproperty
    a_idle_req: assert property (p_idle_req) else $error("idle frame not started");

    property p_idle_first;
        @(posedge clock_i) disable iff (!resetn_i)
        (state == sbit_pkg::SBIT_IDLE) && (next_state == sbit_pkg::SBIT_READY)
        && pend_break && tx_on_i |-> ##2 (state == sbit_pkg::SBIT_BREAK);
    endproperty
    a_idle_first: assert property (p_idle_first) else $error("break not sent after idle");

    c_break:     cover property (@(posedge clock_i) disable iff (!resetn_i)
        $rose(state == sbit_pkg::SBIT_BREAK));
    c_idle_brk:  cover property (@(posedge clock_i) disable iff (!resetn_i)
        (state == sbit_pkg::SBIT_IDLE) && pend_break);
    c_back2back: cover property (@(posedge clock_i) disable iff (!resetn_i)
        (state == sbit_pkg::SBIT_MARK) ##1 (state == sbit_pkg::SBIT_READY)
        ##1 (state == sbit_pkg::SBIT_BREAK));
    c_data:      cover property (@(posedge clock_i) disable iff (!resetn_i)
        fifo_pop && !data_ready_o);

endmodule

// ==== dv/sbit_line_model.sv ====
// far-end receiver model: measures low and high run lengths on the serial line
`timescale 1ns/1ps
module sbit_line_model (
    // clock
    input  wire logic clock_i,
    // serial line
    input  wire logic line_i,
    // measurements
    output int        low_len_o,
    output int        high_len_o,
    output int        runs_o
);
    int   lo_cnt = 0;
    int   hi_cnt = 0;
    logic prev   = 1'h1;

    // a low run is published when the line rises, a high run when it falls
    always @(posedge clock_i) begin
        prev <= line_i;
        if (line_i === 1'h0) begin
            lo_cnt <= lo_cnt + 1;
            if (prev === 1'h1) begin
                high_len_o <= hi_cnt;
                hi_cnt     <= 0;
            end
        end else begin
            hi_cnt <= hi_cnt + 1;
            if (prev === 1'h0) begin
                low_len_o <= lo_cnt;
                runs_o    <= runs_o + 1;
                lo_cnt    <= 0;
            end
        end
    end
endmodule

// ==== dv/sbit_tx_tb.sv ====
// self-checking bench for the break and idle transmit path
`timescale 1ns/1ps
module sbit_tx_tb;
    localparam int B = 4;
    logic                          clock_i;
    logic                          resetn_i;
    logic                          send_break_bit_i;
    logic                          tx_on_i;
    logic                          word_len_i;
    logic [sbit_pkg::DATA_W-1:0]   data_i;
    logic                          data_valid_i;
    logic                          data_ready_o;
    logic                          tx_o;
    logic                          busy_o;
    int                            low_len;
    int                            high_len;
    int                            runs;
    int                            failures;
    int                            check_count;

    sbit_tx #(.BIT_CYCLES(B)) u_dut (
        .clock_i         (clock_i),
        .resetn_i        (resetn_i),
        .send_break_bit_i(send_break_bit_i),
        .tx_on_i         (tx_on_i),
        .word_len_i      (word_len_i),
        .data_i          (data_i),
        .data_valid_i    (data_valid_i),
        .data_ready_o    (data_ready_o),
        .tx_o            (tx_o),
        .busy_o          (busy_o)
    );

    sbit_line_model u_line (
        .clock_i   (clock_i),
        .line_i    (tx_o),
        .low_len_o (low_len),
        .high_len_o(high_len),
        .runs_o    (runs)
    );

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (failures == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_runs(input int n);
        for (int i = 0; i < 4000 && runs < n; i++) begin
            @(negedge clock_i);
        end
        if (runs < n) begin
            failures++;
            $display("Error line runs expected %0d seen %0d", n, runs);
            end_of_test();
        end
    endtask

    task automatic give_up(input string what);
        failures++;
        $display("Error %s expected done seen timeout", what);
        end_of_test();
    endtask

    task automatic t_single(input logic wl, input int bits);
        int r0;
        r0 = runs;
        @(negedge clock_i);
        word_len_i = wl;
        send_break_bit_i = 1'h1;
        @(negedge clock_i);
        send_break_bit_i = 1'h0;
        wait_runs(r0 + 1);
        chk("break length", low_len, bits * B);
        repeat (15 * B) @(negedge clock_i);
        chk("break count", runs, r0 + 1);
        chk("line after break", tx_o, 1);
        word_len_i = 1'h0;
    endtask

    task automatic t_held();
        int r0;
        r0 = runs;
        @(negedge clock_i);
        send_break_bit_i = 1'h1;
        wait_runs(r0 + 1);
        for (int i = 0; i < 3 * B && tx_o !== 1'h0; i++) begin
            @(negedge clock_i);
        end
        if (tx_o !== 1'h0) begin
            give_up("second break start");
        end
        send_break_bit_i = 1'h0;
        wait_runs(r0 + 2);
        chk("gap between breaks", high_len, B + 1);
        chk("second break length", low_len, 10 * B);
        repeat (15 * B) @(negedge clock_i);
        chk("held break count", runs, r0 + 2);
    endtask

    task automatic t_idle();
        int cnt;
        int r0;
        logic low_seen;
        cnt = 0;
        low_seen = 1'h0;
        r0 = runs;
        @(negedge clock_i);
        tx_on_i = 1'h0;
        @(negedge clock_i);
        tx_on_i = 1'h1;
        for (int i = 0; i < 20 * B && !(busy_o === 1'h0 && cnt > 0); i++) begin
            @(negedge clock_i);
            if (busy_o === 1'h1) cnt++;
            if (tx_o !== 1'h1) low_seen = 1'h1;
        end
        if (busy_o !== 1'h0 || cnt == 0) begin
            give_up("idle frame end");
        end
        chk("idle frame length", cnt, 10 * B);
        chk("idle line low", low_seen, 0);
        chk("idle runs", runs, r0);
    endtask

    task automatic t_idle_break();
        int hi;
        int r0;
        hi = 0;
        r0 = runs;
        // nothing else happens between the two requests
        @(negedge clock_i);
        tx_on_i = 1'h0;
        @(negedge clock_i);
        tx_on_i = 1'h1;
        @(negedge clock_i);
        send_break_bit_i = 1'h1;
        @(negedge clock_i);
        send_break_bit_i = 1'h0;
        for (int i = 0; i < 30 * B && tx_o !== 1'h0; i++) begin
            @(negedge clock_i);
            hi++;
        end
        if (tx_o !== 1'h0) begin
            give_up("break after idle start");
        end
        chk("idle before break", hi >= 10 * B - 1, 1);
        wait_runs(r0 + 1);
        chk("break after idle", low_len, 10 * B);
        chk("break after idle count", runs, r0 + 1);
    endtask

    task automatic t_fifo();
        int n;
        int r0;
        n = 0;
        @(negedge clock_i);
        tx_on_i = 1'h0;
        data_i = 9'h1FF;
        data_valid_i = 1'h1;
        for (int i = 0; i < 40 && data_ready_o === 1'h1; i++) begin
            n++;
            @(negedge clock_i);
        end
        data_valid_i = 1'h0;
        if (data_ready_o === 1'h1) begin
            give_up("fifo fill");
        end
        chk("words accepted", n, sbit_pkg::FIFO_DEPTH);
        chk("held while off", busy_o, 0);
        r0 = runs;
        tx_on_i = 1'h1;
        wait_runs(r0 + 16);
        chk("start bit length", low_len, B);
        repeat (15 * B) @(negedge clock_i);
        chk("frames sent", runs, r0 + 16);
        chk("ready after drain", data_ready_o, 1);
    endtask

    // a break pulse during a long data frame waits for the frame, then sends one break
    task automatic t_brk_in_frame();
        int r0;
        r0 = runs;
        @(negedge clock_i);
        word_len_i = 1'h1;
        data_i = 9'h0FF;
        data_valid_i = 1'h1;
        @(negedge clock_i);
        data_valid_i = 1'h0;
        repeat (2) @(negedge clock_i);
        send_break_bit_i = 1'h1;
        @(negedge clock_i);
        send_break_bit_i = 1'h0;
        wait_runs(r0 + 2);
        chk("ninth bit low", low_len, B);
        chk("data high run", high_len, 8 * B);
        wait_runs(r0 + 3);
        chk("break behind frame", low_len, 11 * B);
        chk("mark before break", high_len, B + 1);
        repeat (15 * B) @(negedge clock_i);
        chk("break behind frame count", runs, r0 + 3);
        word_len_i = 1'h0;
    endtask

    initial begin
        clock_i = 1'h0;
        forever #20 clock_i = ~clock_i;
    end

    initial begin
        resetn_i = 1'h0;
        send_break_bit_i = 1'h0;
        tx_on_i = 1'h1;
        word_len_i = 1'h0;
        data_i = 9'h000;
        data_valid_i = 1'h0;
        repeat (12) @(negedge clock_i);
        chk("reset line", tx_o, 1);
        chk("reset busy", busy_o, 0);
        chk("reset ready", data_ready_o, 1);
        resetn_i = 1'h1;
        repeat (2) @(negedge clock_i);
        t_single(1'h0, 10);
        t_single(1'h1, 11);
        t_held();
        t_idle();
        t_idle_break();
        t_fifo();
        t_brk_in_frame();
        end_of_test();
    end
endmodule
